// [test/rdt_partner.sv]
// event pulse source and interrupt controller for one timer channel
// assumes fire and ack_en are driven on clk; the pin idles low between pulses
`timescale 1ns/1ps
module rdt_partner (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // bench commands
  input  wire logic fire,
  input  wire logic ack_en,
  // timer side
  input  wire logic irq,
  output logic      ev_pin,
  output logic      clr
);
  int hi_cnt;
  int ack_wait;

  // one pulse per command; four clocks high so the pin synchroniser sees both edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt <= 0;
      ev_pin <= 1'b0;
    end else begin
      if (fire)
        hi_cnt <= 4;
      else if (hi_cnt > 0)
        hi_cnt <= hi_cnt - 1;
      ev_pin <= fire || (hi_cnt > 1);
    end
  end

  // controller answers a request late, as firmware would, by writing the flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_wait <= 0;
      clr      <= 1'b0;
    end else begin
      clr <= 1'b0;
      if (ack_en && irq && !clr)
        ack_wait <= ack_wait + 1;
      else
        ack_wait <= 0;
      if (ack_wait == 3) begin
        clr      <= 1'b1;
        ack_wait <= 0;
      end
    end
  end
endmodule : rdt_partner

// [test/tb_top.sv]
// self-checking bench for the two-channel reload down timer
// assumes rdt_top and rdt_partner are compiled first; counts kept small
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic        clk, arst_n, ce;
  logic [1:0]  start, stop, rmode, irq_en, fire, ack_en, ev, clr;
  logic [1:0]  csel [2];
  logic [1:0]  esel [2];
  logic [15:0] rval [2];
  logic [15:0] count0, count1;
  logic [1:0]  running, pending, irq, sclk_out;
  int          failures, checks_done, seed, exp_cnt, r, cyc;

  rdt_top i_dut (.clk(clk), .arst_n(arst_n), .ce(ce),
    .start0(start[0]), .stop0(stop[0]), .reload_mode0(rmode[0]), .clk_sel0(csel[0]),
    .edge_sel0(esel[0]), .reload_val0(rval[0]), .irq_en0(irq_en[0]), .pend_clr0(clr[0]),
    .ev_pin0(ev[0]), .start1(start[1]), .stop1(stop[1]), .reload_mode1(rmode[1]),
    .clk_sel1(csel[1]), .edge_sel1(esel[1]), .reload_val1(rval[1]), .irq_en1(irq_en[1]),
    .pend_clr1(clr[1]), .ev_pin1(ev[1]), .count0(count0), .count1(count1),
    .running(running), .pending(pending), .irq(irq), .sclk_out(sclk_out));

  // one partner per channel keeps the channels apart
  for (genvar g = 0; g < 2; g++) begin : g_far
    rdt_partner i_far (.clk(clk), .arst_n(arst_n), .fire(fire[g]), .ack_en(ack_en[g]),
      .irq(irq[g]), .ev_pin(ev[g]), .clr(clr[g]));
  end

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude;
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // one event pulse, then room for both edges to pass the synchroniser
  task automatic pulse(input int ch);
    @(posedge clk) fire[ch] <= 1'b1;
    @(posedge clk) fire[ch] <= 1'b0;
    repeat (14) @(posedge clk);
  endtask : pulse

  task automatic kick(input int ch);
    @(posedge clk) start[ch] <= 1'b1;
    @(posedge clk) start[ch] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : kick

  // clocks between two serial clock toggles, i.e. between two underflows
  task automatic gap(input int ch, output int c);
    logic s;
    int   w;
    s = sclk_out[ch];
    w = 0;
    while (sclk_out[ch] === s && w < 2000) begin
      @(posedge clk);
      w++;
    end
    s = sclk_out[ch];
    c = 0;
    while (sclk_out[ch] === s && c < 2000) begin
      @(posedge clk);
      c++;
    end
  endtask : gap

  // watchdog: the whole sequence needs well under this many clocks
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    conclude();
  end

  initial begin
    {start, stop, rmode, irq_en, fire, ack_en} = '0;
    ce = 1'b1;
    csel = '{2'h0, 2'h0};
    esel = '{2'h0, 2'h0};
    rval = '{16'h0000, 16'h0000};
    failures = 0;
    checks_done = 0;
    seed = 32'h6d74;
    arst_n = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // one-shot event count on channel 0 with a random small reload
    r = 3 + ($random(seed) & 3);
    rval[0] <= r[15:0];
    csel[0] <= rdt_pkg::CSEL_EVENT;
    esel[0] <= rdt_pkg::EDGE_RISE;
    kick(0);
    exp_cnt = r;
    `CHK("running0", 1'b1, running[0])
    repeat (r) begin
      pulse(0);
      exp_cnt--;
      `CHK("count0", exp_cnt[15:0], count0)
    end
    `CHK("pending0 early", 1'b0, pending[0])
    pulse(0);
    `CHK("pending0", 1'b1, pending[0])
    `CHK("stopped0", 1'b0, running[0])
    `CHK("sclk0", 1'b1, sclk_out[0])
    `CHK("irq0 masked", 1'b0, irq[0])
    irq_en[0] <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("irq0", 1'b1, irq[0])
    ack_en[0] <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("pending0 cleared", 1'b0, pending[0])
    // every edge selection, two pulses each, reload mode
    rmode[0] <= 1'b1;
    for (int e = 0; e < 4; e++) begin
      rval[0] <= 16'h0100;
      esel[0] <= e[1:0];
      kick(0);
      pulse(0);
      pulse(0);
      exp_cnt = 16'h0100 - 2 * ((e == 3) ? 2 : ((e == 0) ? 0 : 1));
      `CHK("count0 edges", exp_cnt[15:0], count0)
    end
    // channel 1 on each internal rate, reloading; channel 0 must not move
    rmode[1] <= 1'b1;
    irq_en[1] <= 1'b1;
    ack_en[1] <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      rval[1] <= 16'h0005;
      csel[1] <= k[1:0];
      kick(1);
      gap(1, cyc);
      `CHK("period1", (5 + 1) * (2 << (2 * k)), cyc)
      `CHK("count1 reload", 16'h0005, count1)
      gap(1, cyc);
      `CHK("reperiod1", (5 + 1) * (2 << (2 * k)), cyc)
      `CHK("running1", 1'b1, running[1])
      `CHK("count0 idle", exp_cnt[15:0], count0)
    end
    // enable low for 50 clocks inside one period stretches it by exactly that much
    fork
      begin
        repeat (212) @(posedge clk);
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
      end
      gap(1, cyc);
    join
    `CHK("frozen period1", (5 + 1) * 32 + 50, cyc)
    // stop halts channel 1; the controller then empties its flag
    stop[1] <= 1'b1;
    @(posedge clk) stop[1] <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK("stopped1", 1'b0, running[1])
    `CHK("flag1 cleared", 2'b00, {irq[1], pending[1]})
    conclude();
  end
endmodule : tb_top

// [verilog/rdt_channel.sv]
// one reload down-timer channel
// assumes count ticks and sync'd event samples arrive on the clk domain
`timescale 1ns/1ps
module rdt_channel #(
  parameter int CNT_W = rdt_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // control
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic             reload_mode,
  input  wire logic [1:0]       clk_sel,
  input  wire logic [1:0]       edge_sel,
  input  wire logic [CNT_W-1:0] reload_val,
  input  wire logic [2:0]       pre_tick,
  input  wire logic             ev_edge_rise,
  input  wire logic             ev_edge_fall,
  // status
  output logic                  running,
  output logic [CNT_W-1:0]      count,
  output logic                  uflow
);
  typedef struct packed {
    rdt_pkg::rdt_state_t st;
    logic [CNT_W-1:0]    cnt;
    logic                uf;
  } rdt_ch_t;

  rdt_ch_t r;
  rdt_ch_t next_r;
  logic    tick;

  // pick the counting strobe for this channel
  always_comb begin
    case (clk_sel)
      rdt_pkg::CSEL_DIV0:  tick = pre_tick[0];
      rdt_pkg::CSEL_DIV1:  tick = pre_tick[1];
      rdt_pkg::CSEL_DIV2:  tick = pre_tick[2];
      default: begin
        case (edge_sel)
          rdt_pkg::EDGE_RISE: tick = ev_edge_rise;
          rdt_pkg::EDGE_FALL: tick = ev_edge_fall;
          rdt_pkg::EDGE_BOTH: tick = ev_edge_rise | ev_edge_fall;
          default:            tick = 1'b0;
        endcase
      end
    endcase
  end

  // start loads the counter so that reload+1 ticks later it wraps
  always_comb begin
    next_r    = r;
    next_r.uf = 1'b0;
    case (r.st)
      rdt_pkg::RDT_IDLE: begin
        if (start) begin
          next_r.st  = rdt_pkg::RDT_RUN;
          next_r.cnt = reload_val;
        end
      end
      rdt_pkg::RDT_RUN: begin
        if (stop) begin
          next_r.st = rdt_pkg::RDT_IDLE;
        end else if (start) begin
          next_r.cnt = reload_val; // restart wins over a tick
        end else if (tick) begin
          next_r.cnt = CNT_W'(r.cnt - 1'b1);
          if (r.cnt == '0) begin
            next_r.uf = 1'b1;
            if (reload_mode) begin
              next_r.cnt = reload_val;
            end else begin
              next_r.st = rdt_pkg::RDT_IDLE;
            end
          end
        end
      end
      default: next_r.st = rdt_pkg::RDT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r.st  <= rdt_pkg::RDT_IDLE;
      r.cnt <= CNT_W'(rdt_pkg::CNT_RESET);
      r.uf  <= 1'b0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign running = (r.st == rdt_pkg::RDT_RUN);
  assign count   = r.cnt;
  assign uflow   = r.uf;

  // one-shot underflow always leaves the counter idle
  a_oneshot_stops: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(r.uf) && !$past(reload_mode) |-> r.st == rdt_pkg::RDT_IDLE)
    else $error("one-shot underflow kept running");
  // reload underflow reloads and keeps running
  a_reload_again: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(r.uf) && $past(reload_mode) && $past(ce) && $stable(reload_val)
      |-> r.st == rdt_pkg::RDT_RUN && r.cnt == reload_val)
    else $error("reload underflow did not reload");
  // underflow only from zero
  a_uflow_zero: assert property (@(posedge clk) disable iff (!arst_n)
    r.uf && $past(ce) |-> $past(r.cnt) == '0)
    else $error("underflow from nonzero count");
  // no tick means no change of count while running
  a_count_hold: assert property (@(posedge clk) disable iff (!arst_n)
    ce && r.st == rdt_pkg::RDT_RUN && !tick && !start && !stop |=> $stable(r.cnt))
    else $error("count moved without a tick");
  // a tick decrements a nonzero count by one
  a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
    ce && r.st == rdt_pkg::RDT_RUN && tick && !start && !stop && r.cnt != '0
      |=> r.cnt == CNT_W'($past(r.cnt) - 1'b1))
    else $error("count did not decrement");
endmodule : rdt_channel

// [verilog/rdt_pkg.sv]
// constants and types shared by the two-channel reload down timer
// assumes a single clock domain; no software register bus, controls are ports
// Operation
// - internal clock mode: 16-bit counter decrements at one of three prescaled rates
// - event mode: counter decrements once per selected edge on external pin
// - wrap from 0000 to ffff is the underflow event
// - underflow comes reload value plus one counts after loading
// - reload mode: reload on underflow and keep counting unaided
// - one-shot mode: stop after underflow until started again
// - underflow sets the pending flag and raises interrupt request when enabled
// - two independent channels, each with own counter, reload and mode
// - timer output is offered as clock source to serial interfaces
package rdt_pkg;
  localparam int          CNT_W      = 16;
  localparam int          CHANNELS   = 2;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CNT_ALL1   = 16'hffff;
  // prescaler taps: divide by 2, 8 and 32 of the machine clock
  localparam int          PRE_W      = 5;
  localparam int          TAP0       = 0;
  localparam int          TAP1       = 2;
  localparam int          TAP2       = 4;
  // clock select encodings
  localparam logic [1:0]  CSEL_DIV0  = 2'h0;
  localparam logic [1:0]  CSEL_DIV1  = 2'h1;
  localparam logic [1:0]  CSEL_DIV2  = 2'h2;
  localparam logic [1:0]  CSEL_EVENT = 2'h3;
  // event edge encodings
  localparam logic [1:0]  EDGE_NONE  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_FALL  = 2'h2;
  localparam logic [1:0]  EDGE_BOTH  = 2'h3;

  typedef enum logic [0:0] {RDT_IDLE, RDT_RUN} rdt_state_t;
endpackage : rdt_pkg

// [verilog/rdt_top.sv]
// two-channel reload down timer with pending flags and serial clock outputs
// assumes control inputs are on clk; event pins are asynchronous
`timescale 1ns/1ps
module rdt_top #(
  parameter int CNT_W = rdt_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // channel 0 control
  input  wire logic             start0,
  input  wire logic             stop0,
  input  wire logic             reload_mode0,
  input  wire logic [1:0]       clk_sel0,
  input  wire logic [1:0]       edge_sel0,
  input  wire logic [CNT_W-1:0] reload_val0,
  input  wire logic             irq_en0,
  input  wire logic             pend_clr0,
  input  wire logic             ev_pin0,
  // channel 1 control
  input  wire logic             start1,
  input  wire logic             stop1,
  input  wire logic             reload_mode1,
  input  wire logic [1:0]       clk_sel1,
  input  wire logic [1:0]       edge_sel1,
  input  wire logic [CNT_W-1:0] reload_val1,
  input  wire logic             irq_en1,
  input  wire logic             pend_clr1,
  input  wire logic             ev_pin1,
  // status and requests
  output logic [CNT_W-1:0]      count0,
  output logic [CNT_W-1:0]      count1,
  output logic [1:0]            running,
  output logic [1:0]            pending,
  output logic [1:0]            irq,
  output logic [1:0]            sclk_out
);
  typedef struct packed {
    logic [rdt_pkg::PRE_W-1:0] pre;
    logic [2:0]                ptick;
    logic [1:0]                s1;
    logic [1:0]                s2;
    logic [1:0]                s3;
    logic [1:0]                lvl;
    logic [1:0]                pend;
    logic [1:0]                irq;
    logic [1:0]                sclk;
    logic [1:0]                run;
    logic [CNT_W-1:0]          c0;
    logic [CNT_W-1:0]          c1;
  } rdt_top_t;

  rdt_top_t r;
  rdt_top_t next_r;
  logic [1:0]       uf;
  logic [1:0]       ch_run;
  logic [CNT_W-1:0] ch_cnt0;
  logic [CNT_W-1:0] ch_cnt1;
  logic [1:0]       ev_rise;
  logic [1:0]       ev_fall;

  // edges come from the accepted level; pin idles low, so reset gives no false edge
  assign ev_rise = r.s2 & r.s3 & ~r.lvl;
  assign ev_fall = ~r.s2 & ~r.s3 & r.lvl;

  // tap strobe: fires when the low prescaler bits all read ones
  function automatic logic tap_hit(input logic [rdt_pkg::PRE_W-1:0] p, input int t);
    logic [rdt_pkg::PRE_W-1:0] m;
    m = rdt_pkg::PRE_W'((1 << (t + 1)) - 1);
    return (p & m) == m;
  endfunction : tap_hit

  // next-state of prescaler, pin sync, flags and registered outputs
  always_comb begin
    next_r       = r;
    next_r.pre   = rdt_pkg::PRE_W'(r.pre + 1'b1);
    next_r.ptick = {tap_hit(r.pre, rdt_pkg::TAP2), tap_hit(r.pre, rdt_pkg::TAP1),
                    tap_hit(r.pre, rdt_pkg::TAP0)};
    // three-stage sync; s1 is read only by s2
    next_r.s1    = {ev_pin1, ev_pin0};
    next_r.s2    = r.s1;
    next_r.s3    = r.s2;
    // a new level counts only once stages two and three agree; filters a one-clock glitch
    next_r.lvl   = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));
    // set wins over a same-cycle clear
    next_r.pend  = (r.pend & ~{pend_clr1, pend_clr0}) | uf;
    next_r.irq   = next_r.pend & {irq_en1, irq_en0};
    // underflow toggles the serial baud clock
    next_r.sclk  = r.sclk ^ uf;
    next_r.run   = ch_run;
    next_r.c0    = ch_cnt0;
    next_r.c1    = ch_cnt1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // two independent channels; edge seen when the accepted level moves
  rdt_channel #(.CNT_W(CNT_W)) u_ch0 (
    .clk          (clk),
    .arst_n       (arst_n),
    .ce           (ce),
    .start        (start0),
    .stop         (stop0),
    .reload_mode  (reload_mode0),
    .clk_sel      (clk_sel0),
    .edge_sel     (edge_sel0),
    .reload_val   (reload_val0),
    .pre_tick     (r.ptick),
    .ev_edge_rise (ev_rise[0]),
    .ev_edge_fall (ev_fall[0]),
    .running      (ch_run[0]),
    .count        (ch_cnt0),
    .uflow        (uf[0])
  );
  rdt_channel #(.CNT_W(CNT_W)) u_ch1 (
    .clk          (clk),
    .arst_n       (arst_n),
    .ce           (ce),
    .start        (start1),
    .stop         (stop1),
    .reload_mode  (reload_mode1),
    .clk_sel      (clk_sel1),
    .edge_sel     (edge_sel1),
    .reload_val   (reload_val1),
    .pre_tick     (r.ptick),
    .ev_edge_rise (ev_rise[1]),
    .ev_edge_fall (ev_fall[1]),
    .running      (ch_run[1]),
    .count        (ch_cnt1),
    .uflow        (uf[1])
  );

  assign count0   = r.c0;
  assign count1   = r.c1;
  assign running  = r.run;
  assign pending  = r.pend;
  assign irq      = r.irq;
  assign sclk_out = r.sclk;

  // an underflow always leaves the flag set
  a_pend_set: assert property (@(posedge clk) disable iff (!arst_n)
    ce && uf[0] |=> pending[0])
    else $error("underflow lost its pending flag");
  a_pend_set1: assert property (@(posedge clk) disable iff (!arst_n)
    ce && uf[1] |=> pending[1])
    else $error("underflow lost its pending flag");
  // a write with no new underflow empties the flag
  a_pend_clear0: assert property (@(posedge clk) disable iff (!arst_n)
    ce && pend_clr0 && !uf[0] |=> !pending[0])
    else $error("written flag did not clear");
  a_pend_clear1: assert property (@(posedge clk) disable iff (!arst_n)
    ce && pend_clr1 && !uf[1] |=> !pending[1])
    else $error("written flag did not clear");
  // with neither event the flag keeps its value
  a_pend_hold: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !pend_clr0 && !uf[0] |=> $stable(pending[0]))
    else $error("flag moved without a cause");

  // request follows the flag at the same edge and the enable one cycle later
  a_irq_gate: assert property (@(posedge clk) disable iff (!arst_n)
    ce |=> irq == (r.pend & $past({irq_en1, irq_en0})))
    else $error("irq not gated by enable");
  // an armed underflow raises flag and request at the same edge
  sequence seq_uf_armed1;
    ce && uf[1] && irq_en1;
  endsequence
  sequence seq_req_up1;
    pending[1] && irq[1];
  endsequence
  a_req_follows: assert property (@(posedge clk) disable iff (!arst_n)
    seq_uf_armed1 |=> seq_req_up1)
    else $error("armed underflow gave no request");

  // serial clock flips once per underflow
  a_sclk_flip: assert property (@(posedge clk) disable iff (!arst_n)
    ce && uf[1] |=> sclk_out[1] != $past(sclk_out[1]))
    else $error("serial clock missed underflow");
  a_sclk_flip0: assert property (@(posedge clk) disable iff (!arst_n)
    ce && uf[0] |=> sclk_out[0] != $past(sclk_out[0]))
    else $error("serial clock missed underflow");
  // and holds between underflows, so its rate is half the underflow rate
  a_sclk_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    ce && uf == 2'b00 |=> $stable(sclk_out))
    else $error("serial clock moved without underflow");

  // enable low freezes every flop of the top level, prescaler included
  a_ce_freeze: assert property (@(posedge clk) disable iff (!arst_n)
    !ce |=> $stable(r))
    else $error("state moved while enable low");
  // prescaler steps once per enabled clock; slower taps only fire with faster ones
  a_pre_step: assert property (@(posedge clk) disable iff (!arst_n)
    ce |=> r.pre == rdt_pkg::PRE_W'($past(r.pre) + 1'b1))
    else $error("prescaler skipped a step");
  a_tap_nest: assert property (@(posedge clk) disable iff (!arst_n)
    r.ptick[2] |-> r.ptick[1] && r.ptick[0])
    else $error("slow tap fired alone");
  a_tap_mid: assert property (@(posedge clk) disable iff (!arst_n)
    r.ptick[1] |-> r.ptick[0])
    else $error("middle tap fired alone");

  // count and running outputs are one-cycle registered copies of the channel state
  a_copy_out: assert property (@(posedge clk) disable iff (!arst_n)
    ce |=> count0 == $past(ch_cnt0) && count1 == $past(ch_cnt1)
      && running == $past(ch_run))
    else $error("status output not a copy of channel");

  // agreed late stages move the accepted pin level
  sequence seq_agree_hi0;
    ce && r.s2[0] && r.s3[0] && !r.lvl[0];
  endsequence
  sequence seq_agree_lo0;
    ce && !r.s2[0] && !r.s3[0] && r.lvl[0];
  endsequence
  a_edge_accept: assert property (@(posedge clk) disable iff (!arst_n)
    seq_agree_hi0 |=> r.lvl[0])
    else $error("agreed high level not taken");
  a_edge_release: assert property (@(posedge clk) disable iff (!arst_n)
    seq_agree_lo0 |=> !r.lvl[0])
    else $error("agreed low level not taken");
endmodule : rdt_top
